/* File: core/mts_stats.sv */
/*
  Transmit error, frame-size histogram, network byte and receive overrun
  counters of an Ethernet MAC statistics unit.
  Assumes all status inputs come from MAC logic on i_clk, each frame
  reported by one-cycle strobes with its flags and length valid alongside.
  Counters wrap silently; software is expected to read often enough.
*/
`timescale 1ns/10ps
`include "mts_params.svh"

module mts_stats #(
  parameter int CW = 32
) (
  input wire logic i_clk,                       // 40 MHz clock
  input wire logic i_rst_n,                     // sync reset, active low
  input wire logic i_tx_done,                   // tx frame finished strobe
  input wire mts_pkg::mts_len_t i_tx_len,       // bytes put on the wire
  input wire logic i_tx_underrun,               // frame hit FIFO underrun
  input wire logic i_tx_carrier_loss,           // carrier lost or absent
  input wire logic i_tx_late_coll,              // late collision abort
  input wire logic i_tx_excess_coll,            // excessive collisions
  input wire logic i_tx_coll,                   // attempt ended by collision
  input wire mts_pkg::mts_len_t i_tx_coll_len,  // bytes sent before it
  input wire logic i_rx_done,                   // rx frame finished strobe
  input wire mts_pkg::mts_len_t i_rx_len,       // bytes received
  input wire logic i_rx_accepted,               // address matched/promisc
  input wire logic i_rx_start_ovr,              // no fifo/buffer at start
  input wire logic i_rx_middle_ovr,             // ran out mid-frame
  input wire logic i_rx_buffer_ovr,             // zero head descriptor
  input wire mts_pkg::mts_len_t i_max_rx_len,   // largest bucket top
  output logic [CW-1:0] o_tx_fifo_starve_count,   // underrun frames
  output logic [CW-1:0] o_tx_carrier_loss_count,  // carrier error frames
  output logic [CW-1:0] o_tx_good_byte_count,     // good tx bytes
  output logic [CW-1:0] o_size_bucket_min,        // exactly 64
  output logic [CW-1:0] o_size_bucket_second,     // 65..127
  output logic [CW-1:0] o_size_bucket_third,      // 128..255
  output logic [CW-1:0] o_size_bucket_fourth,     // 256..511
  output logic [CW-1:0] o_size_bucket_fifth,      // 512..1023
  output logic [CW-1:0] o_size_bucket_largest,    // 1024..max
  output logic [CW-1:0] o_network_byte_count,     // utilisation bytes
  output logic [CW-1:0] o_rx_start_overrun_count, // start overruns
  output logic [CW-1:0] o_rx_middle_overrun_count,// middle overruns
  output logic [CW-1:0] o_rx_buffer_overrun_count // dma overruns
);
  import mts_pkg::*;

  // one-hot bucket decode; zero when the length fits no bucket
  function automatic mts_bkt_t bucket_of(input mts_len_t len,
                                         input mts_len_t max_len);
    mts_bkt_t hit;
    hit = '0;
    hit[`MTS_BKT_MIN] = (len == `MTS_LEN_64);
    hit[`MTS_BKT_SECOND] = (len > `MTS_LEN_64) &&
                           (len <= `MTS_LEN_127);
    hit[`MTS_BKT_THIRD] = (len > `MTS_LEN_127) &&
                          (len <= `MTS_LEN_255);
    hit[`MTS_BKT_FOURTH] = (len > `MTS_LEN_255) &&
                           (len <= `MTS_LEN_511);
    hit[`MTS_BKT_FIFTH] = (len > `MTS_LEN_511) &&
                          (len <= `MTS_LEN_1023);
    hit[`MTS_BKT_LARGEST] = (len >= `MTS_LEN_1024) &&
                            (len <= max_len);
    return hit;
  endfunction

  // transmit qualification
  wire logic tx_len_is_64;
  wire logic tx_coll_fail;
  wire logic tx_good;
  wire logic tx_hist_ok;
  wire logic tx_starve_inc;
  wire logic tx_carrier_inc;

  assign tx_len_is_64 = (i_tx_len == `MTS_LEN_64);
  assign tx_coll_fail = i_tx_late_coll | i_tx_excess_coll;
  // other error flags deliberately play no part here
  assign tx_starve_inc = i_tx_done & i_tx_underrun;
  assign tx_carrier_inc = i_tx_done & i_tx_carrier_loss;
  assign tx_good = i_tx_done & ~tx_coll_fail & ~i_tx_carrier_loss &
                   ~i_tx_underrun;
  // carrier loss only disqualifies unless the stub came out at 64
  assign tx_hist_ok = i_tx_done & ~tx_coll_fail & ~i_tx_underrun &
                      (~i_tx_carrier_loss | tx_len_is_64);

  // receive frames are bucketed whatever their error flags
  wire logic rx_hist_ok;
  assign rx_hist_ok = i_rx_done;

  wire mts_bkt_t tx_bkt;
  wire mts_bkt_t rx_bkt;
  assign tx_bkt = tx_hist_ok ? bucket_of(i_tx_len, i_max_rx_len) : '0;
  assign rx_bkt = rx_hist_ok ? bucket_of(i_rx_len, i_max_rx_len) : '0;

  // receive overrun qualification; crc/align/code never looked at
  wire logic rx_acc_done;
  wire logic rx_start_inc;
  wire logic rx_middle_inc;
  wire logic rx_buffer_inc;
  assign rx_acc_done = i_rx_done & i_rx_accepted;
  assign rx_start_inc = rx_acc_done & i_rx_start_ovr;
  // a frame already counted as a start overrun is never a middle one
  assign rx_middle_inc = rx_acc_done & i_rx_middle_ovr &
                         ~i_rx_start_ovr;
  assign rx_buffer_inc = rx_acc_done & i_rx_buffer_ovr;

  // network bytes: tx frames, aborted attempts and rx frames may all
  // land in one cycle, so the three terms are summed, not muxed
  wire logic [CW-1:0] net_tx;
  wire logic [CW-1:0] net_coll;
  wire logic [CW-1:0] net_rx;
  wire logic [CW-1:0] net_add;
  wire logic [CW-1:0] good_add;
  assign net_tx = i_tx_done ? CW'(i_tx_len) : '0;
  assign net_coll = i_tx_coll ? CW'(i_tx_coll_len) : '0;
  // partner reports rx length cut at the jam, jam bytes excluded
  assign net_rx = i_rx_done ? CW'(i_rx_len) : '0;
  assign net_add = net_tx + net_coll + net_rx;
  assign good_add = tx_good ? CW'(i_tx_len) : '0;

  logic [CW-1:0] starve_q;
  logic [CW-1:0] carrier_q;
  logic [CW-1:0] good_q;
  logic [CW-1:0] net_q;
  logic [CW-1:0] sof_q;
  logic [CW-1:0] mof_q;
  logic [CW-1:0] dma_q;
  // a net array, so each bucket register below keeps a single driver
  wire logic [CW-1:0] bkt_w [`MTS_NBUCKET];

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      starve_q <= '0;
      carrier_q <= '0;
      good_q <= '0;
      net_q <= '0;
      sof_q <= '0;
      mof_q <= '0;
      dma_q <= '0;
    end else begin
      starve_q <= starve_q + CW'(tx_starve_inc);
      carrier_q <= carrier_q + CW'(tx_carrier_inc);
      good_q <= good_q + good_add;
      net_q <= net_q + net_add;
      sof_q <= sof_q + CW'(rx_start_inc);
      mof_q <= mof_q + CW'(rx_middle_inc);
      dma_q <= dma_q + CW'(rx_buffer_inc);
    end
  end

  // a tx and an rx frame can fall in the same bucket in one cycle
  genvar b;
  generate
    for (b = 0; b < `MTS_NBUCKET; b++) begin : g_bkt
      wire logic [1:0] inc;
      logic [CW-1:0] cnt_q;
      assign inc = {1'b0, tx_bkt[b]} + {1'b0, rx_bkt[b]};
      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          cnt_q <= '0;
        end else begin
          cnt_q <= cnt_q + CW'(inc);
        end
      end
      assign bkt_w[b] = cnt_q;
    end
  endgenerate

  assign o_tx_fifo_starve_count = starve_q;
  assign o_tx_carrier_loss_count = carrier_q;
  assign o_tx_good_byte_count = good_q;
  assign o_size_bucket_min = bkt_w[`MTS_BKT_MIN];
  assign o_size_bucket_second = bkt_w[`MTS_BKT_SECOND];
  assign o_size_bucket_third = bkt_w[`MTS_BKT_THIRD];
  assign o_size_bucket_fourth = bkt_w[`MTS_BKT_FOURTH];
  assign o_size_bucket_fifth = bkt_w[`MTS_BKT_FIFTH];
  assign o_size_bucket_largest = bkt_w[`MTS_BKT_LARGEST];
  assign o_network_byte_count = net_q;
  assign o_rx_start_overrun_count = sof_q;
  assign o_rx_middle_overrun_count = mof_q;
  assign o_rx_buffer_overrun_count = dma_q;

endmodule

/* File: core/mts_params.svh */
/*
  Constants for the transmit, size-histogram and overrun statistics block.
  Assumes it is included by bare name from the package and the design.
*/
`ifndef MTS_PARAMS_SVH
`define MTS_PARAMS_SVH

`define MTS_LEN_W 16
`define MTS_NBUCKET 6
`define MTS_LEN_64 16'h0040
`define MTS_LEN_127 16'h007F
`define MTS_LEN_255 16'h00FF
`define MTS_LEN_511 16'h01FF
`define MTS_LEN_1023 16'h03FF
`define MTS_LEN_1024 16'h0400
`define MTS_MAX_RX_LEN_RST 16'h05EE
`define MTS_BKT_MIN 0
`define MTS_BKT_SECOND 1
`define MTS_BKT_THIRD 2
`define MTS_BKT_FOURTH 3
`define MTS_BKT_FIFTH 4
`define MTS_BKT_LARGEST 5

`endif

/* File: core/mts_pkg.sv */
/*
  Types shared by the statistics block and its bench.
  Assumes mts_params.svh is on the include path.
*/
`include "mts_params.svh"

package mts_pkg;
  typedef logic [`MTS_LEN_W-1:0] mts_len_t;
  typedef logic [`MTS_NBUCKET-1:0] mts_bkt_t;
endpackage

/* File: tb/mts_stats_assertions.sv */
/* Port checker for the statistics counters.
   Assumes it is bound onto mts_stats with all events on i_clk. */
`timescale 1ns/10ps
`include "mts_params.svh"
module mts_stats_assertions #(parameter int CW = 32) (
  input wire logic i_clk, i_rst_n, // clock, sync reset
  input wire logic i_tx_done, i_tx_underrun, i_tx_carrier_loss, // tx
  input wire logic i_tx_late_coll, i_tx_excess_coll, i_tx_coll, // tx
  input wire logic i_rx_done, i_rx_accepted, i_rx_start_ovr, // rx
  input wire logic i_rx_middle_ovr, i_rx_buffer_ovr, // rx flags
  input wire mts_pkg::mts_len_t i_tx_len, i_tx_coll_len, i_rx_len, // len
  input wire logic [CW-1:0] o_tx_fifo_starve_count, // counter
  input wire logic [CW-1:0] o_tx_carrier_loss_count, // counter
  input wire logic [CW-1:0] o_tx_good_byte_count, o_size_bucket_min, // ctr
  input wire logic [CW-1:0] o_size_bucket_second, o_network_byte_count,
  input wire logic [CW-1:0] o_rx_start_overrun_count, // counter
  input wire logic [CW-1:0] o_rx_middle_overrun_count, // counter
  input wire logic [CW-1:0] o_rx_buffer_overrun_count // counter
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire tx_bad = i_tx_late_coll | i_tx_excess_coll | i_tx_underrun;
  wire rx_ok = i_rx_done & i_rx_accepted;
  AST_STARVE: assert property (i_tx_done && i_tx_underrun |=>
    o_tx_fifo_starve_count == CW'($past(o_tx_fifo_starve_count) + 1))
    else $error("underrun count did not step");
  AST_CARRIER: assert property (i_tx_done && i_tx_carrier_loss |=>
    o_tx_carrier_loss_count == CW'($past(o_tx_carrier_loss_count) + 1))
    else $error("carrier count did not step");
  AST_GOOD: assert property (i_tx_done && !tx_bad && !i_tx_carrier_loss
    |=> o_tx_good_byte_count == CW'($past(o_tx_good_byte_count + i_tx_len)))
    else $error("good byte count wrong");
  AST_MIN: assert property (i_tx_done && !tx_bad && !i_rx_done &&
    i_tx_len == `MTS_LEN_64 |=>
    o_size_bucket_min == CW'($past(o_size_bucket_min) + 1))
    else $error("64 byte bucket did not step");
  AST_SECOND: assert property (i_rx_done && !i_tx_done &&
    i_rx_len inside {[16'h0041:16'h007F]} |=>
    o_size_bucket_second == CW'($past(o_size_bucket_second) + 1))
    else $error("second bucket did not step");
  AST_NET: assert property (1'b1 |=> o_network_byte_count ==
    CW'($past(o_network_byte_count + (i_tx_done ? i_tx_len : 16'h0000) +
    (i_tx_coll ? i_tx_coll_len : 16'h0000) +
    (i_rx_done ? i_rx_len : 16'h0000))))
    else $error("network byte count wrong");
  AST_SOV: assert property (rx_ok && i_rx_start_ovr |=>
    o_rx_start_overrun_count == CW'($past(o_rx_start_overrun_count) + 1))
    else $error("start overrun count did not step");
  AST_MOV: assert property (rx_ok && i_rx_middle_ovr && !i_rx_start_ovr
    |=> o_rx_middle_overrun_count ==
    CW'($past(o_rx_middle_overrun_count) + 1))
    else $error("middle overrun count did not step");
  AST_BOV: assert property (!rx_ok |=>
    $stable(o_rx_buffer_overrun_count))
    else $error("buffer overrun count moved without an accepted frame");
endmodule

/* File: tb/mts_mac_model.sv */
/* Model of the MAC status logic feeding the counters.
   Assumes one-cycle strobes driven 1 ns after the rising edge. */
`timescale 1ns/10ps
module mts_mac_model (
  input wire logic i_clk, // clock
  output logic i_tx_done = 1'b0, i_tx_coll = 1'b0, i_rx_done = 1'b0, // stb
  output logic [3:0] tf = 4'h0, rf = 4'h0, // flag groups
  output mts_pkg::mts_len_t i_tx_len = '0, i_tx_coll_len = '0, // lengths
  output mts_pkg::mts_len_t i_rx_len = '0 // rx length
);
  task automatic tx(input mts_pkg::mts_len_t n, input logic [3:0] f);
    @(posedge i_clk) #1 {i_tx_done, i_tx_len, tf} = {1'b1, n, f};
    @(posedge i_clk) #1 {i_tx_done, i_tx_len, tf} = {1'b0, ~n, ~f};
  endtask
  // one aborted attempt; each retry reports its own stub
  task automatic coll(input mts_pkg::mts_len_t n);
    @(posedge i_clk) #1 {i_tx_coll, i_tx_coll_len} = {1'b1, n};
    @(posedge i_clk) #1 {i_tx_coll, i_tx_coll_len} = {1'b0, ~n};
  endtask
  // length already stops at the jam in half duplex
  task automatic rx(input mts_pkg::mts_len_t n, input logic [3:0] f);
    @(posedge i_clk) #1 {i_rx_done, i_rx_len, rf} = {1'b1, n, f};
    @(posedge i_clk) #1 {i_rx_done, i_rx_len, rf} = {1'b0, ~n, ~f};
  endtask
endmodule

/* File: tb/tb_mts_stats.sv */
/* Self-checking bench for the statistics counters.
   Assumes the MAC model drives every status input. */
`timescale 1ns/10ps
`include "mts_params.svh"
module tb_mts_stats;
  localparam int CW = 32;
  logic i_clk = 1'b0, i_rst_n = 1'b0;
  mts_pkg::mts_len_t i_max_rx_len = `MTS_MAX_RX_LEN_RST;
  wire logic i_tx_done, i_tx_coll, i_rx_done;
  wire logic [3:0] tf, rf;
  wire mts_pkg::mts_len_t i_tx_len, i_tx_coll_len, i_rx_len;
  wire logic [CW-1:0] o_tx_fifo_starve_count, o_tx_carrier_loss_count;
  wire logic [CW-1:0] o_tx_good_byte_count, o_size_bucket_min;
  wire logic [CW-1:0] o_size_bucket_second, o_size_bucket_third;
  wire logic [CW-1:0] o_size_bucket_fourth, o_size_bucket_fifth;
  wire logic [CW-1:0] o_size_bucket_largest, o_network_byte_count;
  wire logic [CW-1:0] o_rx_start_overrun_count, o_rx_middle_overrun_count;
  wire logic [CW-1:0] o_rx_buffer_overrun_count;
  wire logic i_tx_underrun = tf[3], i_tx_carrier_loss = tf[2];
  wire logic i_tx_late_coll = tf[1], i_tx_excess_coll = tf[0];
  wire logic i_rx_accepted = rf[3], i_rx_start_ovr = rf[2];
  wire logic i_rx_middle_ovr = rf[1], i_rx_buffer_ovr = rf[0];
  int mismatches = 0, checks = 0;
  logic [CW-1:0] en = '0;
  mts_pkg::mts_len_t lens [11] = '{16'h0041, 16'h007F, 16'h0080, 16'h00FF,
    16'h0100, 16'h01FF, 16'h0200, 16'h03FF, 16'h0400, 16'h05EE, 16'h05EF};
  mts_stats #(.CW(CW)) i_dut (.*);
  mts_mac_model i_mac (.*);
  always #12.5 i_clk = ~i_clk;
  task chk(input string n, input logic [CW-1:0] e, g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s exp %0h got %0h", n, e, g);
    end
  endtask
  task finish_test;
    if (mismatches == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task sc_tx;
    i_mac.tx(16'h0040, 4'h0);
    i_mac.tx(16'h00C8, 4'hA);
    chk("starve", 1, o_tx_fifo_starve_count);
    i_mac.tx(16'h0040, 4'h4);
    chk("carrier", 1, o_tx_carrier_loss_count);
    chk("min", 2, o_size_bucket_min);
    i_mac.coll(16'h001E);
    i_mac.tx(16'h0064, 4'h0);
    chk("good", 16'h00A4, o_tx_good_byte_count);
    chk("net", 16'h01CA, o_network_byte_count);
    en = 16'h01CA;
  endtask
  task sc_buckets;
    foreach (lens[k]) begin
      i_mac.rx(lens[k], 4'h2);
      en += lens[k];
    end
    chk("second", 3, o_size_bucket_second);
    chk("third", 2, o_size_bucket_third);
    chk("fourth", 2, o_size_bucket_fourth);
    chk("fifth", 2, o_size_bucket_fifth);
    chk("largest", 2, o_size_bucket_largest);
    chk("net", en, o_network_byte_count);
  endtask
  task sc_ovr;
    i_mac.rx(16'h0046, 4'hF);
    i_mac.rx(16'h0046, 4'hA);
    i_mac.rx(16'h0046, 4'h7);
    chk("start", 1, o_rx_start_overrun_count);
    chk("middle", 1, o_rx_middle_overrun_count);
    chk("buffer", 1, o_rx_buffer_overrun_count);
  endtask
  initial begin
    repeat (10) @(posedge i_clk);
    #1 i_rst_n = 1'b1;
    chk("reset", 0, o_network_byte_count | o_size_bucket_min);
    sc_tx();
    sc_buckets();
    sc_ovr();
    finish_test();
  end
  initial begin
    #100us;
    mismatches++;
    finish_test();
  end
endmodule
bind mts_stats mts_stats_assertions #(.CW(CW)) i_chk (.*);
